// ### blrb_pkg.sv
// shared constants and carrier types of the backlight register bank
`default_nettype none

package blrb_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BRIGHT_HI = 8'h00;
  localparam logic [7:0] ADDR_BRIGHT_LO = 8'h01;
  localparam logic [7:0] ADDR_DIM_CFG = 8'h02;
  localparam logic [7:0] ADDR_LIGHT_LOAD = 8'h03;
  localparam logic [7:0] ADDR_BOOST = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // reset values
  localparam logic [7:0] RST_BRIGHT_HI = 8'hFF;
  localparam logic [2:0] RST_BRIGHT_LO = 3'h7;
  localparam logic [7:0] RST_DIM_CFG = 8'hFF;
  localparam logic [7:0] RST_LIGHT_LOAD = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'hFA;
  localparam logic [7:0] RST_STATUS = 8'h0F;
  localparam logic [7:0] CFG_CLEAR_VALUE = 8'h00;

  // field positions
  localparam int BRIGHT_LO_W = 3;
  localparam int LIGHT_PEAK_LSB = 4;
  localparam int LIGHT_ENTRY_LSB = 0;
  localparam int STS_LATCH_LSB = 4;

  // brightness widths
  localparam int BRIGHT_W = 11;
  localparam int LIN_BITS = 8;
  localparam int LOG_BITS = 11;
  localparam int SW_CNT_W = 4;
  localparam logic [3:0] SW_CNT_SAT = 4'hC;
  // codes whose bits 5:1 equal this get dithered
  localparam logic [4:0] DITHER_MATCH = 5'h1E;

  // dimming source and law codes
  localparam logic [1:0] MODE_PWM_SW_LIN = 2'h3;
  localparam logic [1:0] MODE_PWM_I2C_LIN = 2'h2;
  localparam logic [1:0] MODE_SW_I2C_LOG = 2'h1;
  localparam logic [1:0] MODE_SW_I2C_LIN = 2'h0;

  // single-wire pulse timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int ONE_MIN_NS = 15000;
  localparam int ONE_MAX_NS = 45000;
  localparam int ZERO_MIN_NS = 90000;
  localparam int ZERO_MAX_NS = 120000;
  localparam int LOAD_MIN_NS = 215000;
  localparam int ONE_MIN_CYC = (ONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONE_MAX_CYC = ONE_MAX_NS / CLK_PERIOD_NS;
  localparam int ZERO_MIN_CYC = (ZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZERO_MAX_CYC = ZERO_MAX_NS / CLK_PERIOD_NS;
  localparam int LOAD_MIN_CYC = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 13;

  typedef struct packed {
    logic [1:0] mode;
    logic fault_en;
    logic short_prot_en;
    logic ov_thresh_hi;
    logic dither_dis;
    logic ch_second_en;
    logic ch_first_en;
  } blrb_dim_cfg_t;

  typedef struct packed {
    logic [1:0] slew;
    logic sync_skip;
    logic audio_band_suppression_en;
    logic [3:0] freq_code;
  } blrb_boost_cfg_t;

  // upper four are event pulses, lower four are live levels
  typedef struct packed {
    logic overtemp;
    logic overvoltage_or_open;
    logic output_short;
    logic current_limit_repeat;
    logic boost_pwm;
    logic leds_on;
    logic ch_second_ok;
    logic ch_first_ok;
  } blrb_status_t;

endpackage

`default_nettype wire

// ### blrb_single_wire_brightness_input_rx.sv
// single-wire brightness line pulse width classifier
`default_nettype none

module blrb_sw_rx #(
  parameter int P_LOAD_CYC = blrb_pkg::LOAD_MIN_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_line,
  output logic o_bit_valid,
  output logic o_bit_one,
  output logic o_load
);

  localparam int CW = blrb_pkg::CNT_W;

  logic line_meta_r;
  logic line_r;
  logic line_prev_r;
  logic [CW-1:0] cnt_r;
  logic bit_valid_r;
  logic bit_one_r;
  logic load_r;
  logic rise;

  // pin is asynchronous to i_clock
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      line_meta_r <= 1'b1;
      line_r <= 1'b1;
      line_prev_r <= 1'b1;
    end
    else
    begin
      line_meta_r <= i_line;
      line_r <= line_meta_r;
      line_prev_r <= line_r;
    end
  end

  assign rise = line_r && !line_prev_r;

  // low time measured only by how long the line stays low [RULE_15]
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cnt_r <= '0;
    else if (!i_enable || line_r)
      cnt_r <= '0;
    else if (cnt_r != {CW{1'b1}})
      cnt_r <= cnt_r + CW'(1);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      bit_valid_r <= 1'b0;
      bit_one_r <= 1'b0;
      load_r <= 1'b0;
    end
    else
    begin
      bit_valid_r <= 1'b0;
      load_r <= 1'b0;
      if (i_enable && rise && cnt_r >= CW'(blrb_pkg::ONE_MIN_CYC)
          && cnt_r <= CW'(blrb_pkg::ONE_MAX_CYC))
      begin
        bit_valid_r <= 1'b1; // [RULE_16]
        bit_one_r <= 1'b1;
      end
      else if (i_enable && rise && cnt_r >= CW'(blrb_pkg::ZERO_MIN_CYC)
               && cnt_r <= CW'(blrb_pkg::ZERO_MAX_CYC))
      begin
        bit_valid_r <= 1'b1; // [RULE_17]
        bit_one_r <= 1'b0;
      end
      // load fires once, while the line is still low
      if (i_enable && !line_r && cnt_r == CW'(P_LOAD_CYC - 1))
        load_r <= 1'b1; // [RULE_18]
    end
  end

  assign o_bit_valid = bit_valid_r;
  assign o_bit_one = bit_one_r;
  assign o_load = load_r;

  property p_one_width;
    @(posedge i_clock) disable iff (i_sys_rst)
    (o_bit_valid && o_bit_one) |-> ($past(cnt_r) >= CW'(blrb_pkg::ONE_MIN_CYC)
      && $past(cnt_r) <= CW'(blrb_pkg::ONE_MAX_CYC));
  endproperty
  a_one_width: assert property (p_one_width) else $error("one bit from bad width"); // [RULE_16]

  property p_zero_width;
    @(posedge i_clock) disable iff (i_sys_rst)
    (o_bit_valid && !o_bit_one) |-> ($past(cnt_r) >= CW'(blrb_pkg::ZERO_MIN_CYC)
      && $past(cnt_r) <= CW'(blrb_pkg::ZERO_MAX_CYC));
  endproperty
  a_zero_width: assert property (p_zero_width) else $error("zero bit from bad width"); // [RULE_17]

  property p_load_single;
    @(posedge i_clock) disable iff (i_sys_rst)
    o_load |=> !o_load [*2];
  endproperty
  a_load_single: assert property (p_load_single) else $error("load pulse repeated"); // [RULE_18]

endmodule

`default_nettype wire

// ### blrb_backlight_regs.sv
// register bank and single-wire brightness receiver of the backlight driver
// Function
// RULE_01 - each register is a byte; a write takes effect after its last bit
// RULE_02 - all registers load their default values at power-on or reset
// RULE_03 - host writes reserved bits as documented and never unmapped addresses
// RULE_04 - only a supply cycle returns the whole register set to defaults
// RULE_05 - brightness is 11 bits: 10..3 at 00h, 2..0 at 01h
// RULE_06 - write to 01h is held until 00h is next written
// RULE_07 - config bits 7:6 pick dimming source pair and linear or log law
// RULE_08 - config bit 5 enables overcurrent and over-temperature responses
// RULE_09 - config bit 3 picks overvoltage threshold: 1 high, 0 low
// RULE_10 - dither, when enabled by bit 2 low, modulates codes 60..61 mod 64
// RULE_11 - config bits 1 and 0 enable the second and first LED channel
// RULE_12 - register 03h is ignored until first written, then overrides defaults
// RULE_13 - boost register bit 4 enables audio band suppression
// RULE_14 - boost register low nibble selects the switching frequency
// RULE_15 - line idles high; symbols are the length of open-drain low pulses
// RULE_16 - low pulse 15 to 45 us is a one bit
// RULE_17 - low pulse 90 to 120 us is a zero bit
// RULE_18 - low pulse over 215 us loads collected bits as brightness
// RULE_19 - host keeps the line high at least 3 us between pulses
// RULE_20 - too many bits before load discards the sequence, brightness unchanged
// RULE_21 - fewer bits than 8 linear or 11 log are scaled to full code
// RULE_22 - receiver value clears on power cycle and on 00h written to 02h
// RULE_23 - first received bit is the most significant one
// RULE_24 - status byte latches four fault events and shows four live levels
// RULE_25 - boost register bit 5 picks pulse skipping (1) or pure pulse frequency
// RULE_26 - enable pin low disables all dimming interfaces, registers are kept
`default_nettype none

module blrb_backlight_regs #(
  parameter int P_LOAD_CYC = blrb_pkg::LOAD_MIN_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_line,
  input wire blrb_pkg::blrb_status_t i_status,
  output logic [7:0] o_rd_data,
  output blrb_pkg::blrb_dim_cfg_t o_dim_cfg,
  output blrb_pkg::blrb_boost_cfg_t o_boost_cfg,
  output logic [10:0] o_i2c_code,
  output logic [10:0] o_sw_code,
  output logic o_use_pwm,
  output logic o_use_sw,
  output logic o_use_i2c,
  output logic o_log_mode,
  output logic o_dither_now,
  output logic o_light_cfg_valid,
  output logic [3:0] o_peak_code,
  output logic [3:0] o_entry_code,
  output logic o_interfaces_on
);

  localparam int LW = blrb_pkg::BRIGHT_LO_W;

  function automatic logic blrb_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // stretch a short MSB-first sequence to full width by repeating it
  function automatic logic [10:0] blrb_scale(input logic [10:0] bits, input logic [3:0] n,
    input logic log_mode);
    logic [10:0] r;
    int w;
    int j;
    r = '0;
    w = log_mode ? blrb_pkg::LOG_BITS : blrb_pkg::LIN_BITS;
    j = 0;
    for (int p = 0; p < blrb_pkg::BRIGHT_W; p++)
    begin
      if (p < w && n != 4'h0)
      begin
        j = (w - 1 - p) % int'(n);
        r[p] = bits[int'(n) - 1 - j]; // [RULE_21] [RULE_23]
      end
    end
    return r;
  endfunction

  logic en_meta_r;
  logic en_sync_r;
  logic [7:0] hi_r;
  logic [LW-1:0] lo_r;
  logic [7:0] cfg_r;
  logic [7:0] light_r;
  logic light_wr_r;
  logic [7:0] boost_r;
  logic [10:0] i2c_code_r;
  logic [3:0] sts_lat_r;
  logic [7:0] rd_data_r;
  logic [10:0] sw_bits_r;
  logic [3:0] sw_cnt_r;
  logic [10:0] sw_code_r;
  logic wr_ok;
  logic cfg_clear;
  logic rx_bit_valid;
  logic rx_bit_one;
  logic rx_load;
  logic [3:0] max_bits;
  blrb_pkg::blrb_dim_cfg_t cfg_view;
  blrb_pkg::blrb_status_t sts_view;

  // enable pin is asynchronous
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end
    else
    begin
      en_meta_r <= i_enable;
      en_sync_r <= en_meta_r;
    end
  end

  // write strobe arrives only after the last data bit is in [RULE_01]
  // while disabled, writes are dropped and contents stay [RULE_26]
  assign wr_ok = i_wr_en && en_sync_r;
  assign cfg_clear = wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_DIM_CFG)
                     && i_wr_data == blrb_pkg::CFG_CLEAR_VALUE;

  // only reset restores defaults; no software path clears the set [RULE_02] [RULE_04]
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hi_r <= blrb_pkg::RST_BRIGHT_HI;
      lo_r <= blrb_pkg::RST_BRIGHT_LO;
      i2c_code_r <= {blrb_pkg::RST_BRIGHT_HI, blrb_pkg::RST_BRIGHT_LO};
    end
    else if (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BRIGHT_LO))
      lo_r <= i_wr_data[LW-1:0]; // [RULE_06]
    else if (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BRIGHT_HI))
    begin
      hi_r <= i_wr_data;
      i2c_code_r <= {i_wr_data, lo_r}; // [RULE_05] [RULE_06]
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cfg_r <= blrb_pkg::RST_DIM_CFG;
    else if (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_DIM_CFG))
      cfg_r <= i_wr_data; // [RULE_07] [RULE_08] [RULE_09] [RULE_11]
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      light_r <= blrb_pkg::RST_LIGHT_LOAD;
      light_wr_r <= 1'b0;
    end
    else if (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_LIGHT_LOAD))
    begin
      light_r <= i_wr_data;
      light_wr_r <= 1'b1; // [RULE_12]
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      boost_r <= blrb_pkg::RST_BOOST;
    else if (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BOOST))
      boost_r <= i_wr_data; // [RULE_13] [RULE_14] [RULE_25]
  end

  // fault events stick until reset; there is no clear-on-read
  assign sts_view = i_status;
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sts_lat_r <= blrb_pkg::RST_STATUS[7:4];
    else
      sts_lat_r <= sts_lat_r | {sts_view.overtemp, sts_view.overvoltage_or_open,
                                sts_view.output_short, sts_view.current_limit_repeat}; // [RULE_24]
  end

  // one-cycle read latency; unmapped and reserved bits read zero
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rd_data_r <= 8'h00;
    else
    begin
      case (i_rd_addr)
        blrb_pkg::ADDR_BRIGHT_HI: rd_data_r <= hi_r;
        blrb_pkg::ADDR_BRIGHT_LO: rd_data_r <= {5'h00, lo_r};
        blrb_pkg::ADDR_DIM_CFG: rd_data_r <= cfg_r;
        blrb_pkg::ADDR_LIGHT_LOAD: rd_data_r <= light_r;
        blrb_pkg::ADDR_BOOST: rd_data_r <= boost_r;
        blrb_pkg::ADDR_STATUS: rd_data_r <= {sts_lat_r, sts_view.boost_pwm,
                                             sts_view.leds_on, sts_view.ch_second_ok,
                                             sts_view.ch_first_ok}; // [RULE_24]
        default: rd_data_r <= 8'h00;
      endcase
    end
  end

  blrb_sw_rx #(
    .P_LOAD_CYC(P_LOAD_CYC)
  ) u_rx (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_enable(en_sync_r), // [RULE_26]
    .i_line(i_line),
    .o_bit_valid(rx_bit_valid),
    .o_bit_one(rx_bit_one),
    .o_load(rx_load)
  );

  assign cfg_view = cfg_r;
  assign max_bits = (cfg_view.mode == blrb_pkg::MODE_SW_I2C_LOG) ? 4'hB : 4'h8;

  // count saturates above any legal length so overflow stays visible
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sw_bits_r <= '0;
      sw_cnt_r <= 4'h0;
    end
    else if (!en_sync_r || cfg_clear || rx_load)
    begin
      sw_bits_r <= '0;
      sw_cnt_r <= 4'h0;
    end
    else if (rx_bit_valid)
    begin
      sw_bits_r <= {sw_bits_r[9:0], rx_bit_one}; // [RULE_23]
      if (sw_cnt_r != blrb_pkg::SW_CNT_SAT)
        sw_cnt_r <= sw_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sw_code_r <= '0; // [RULE_22]
    else if (cfg_clear)
      sw_code_r <= '0; // [RULE_22]
    else if (rx_load && sw_cnt_r != 4'h0 && sw_cnt_r <= max_bits) // [RULE_20]
      sw_code_r <= blrb_scale(sw_bits_r, sw_cnt_r,
                              cfg_view.mode == blrb_pkg::MODE_SW_I2C_LOG); // [RULE_18]
  end

  assign o_rd_data = rd_data_r;
  assign o_dim_cfg = cfg_r;
  assign o_boost_cfg = boost_r;
  assign o_i2c_code = i2c_code_r;
  assign o_sw_code = sw_code_r;
  assign o_interfaces_on = en_sync_r;

  // source pair and law per mode [RULE_07]
  assign o_use_pwm = en_sync_r && cfg_view.mode[1];
  assign o_use_sw = en_sync_r && (cfg_view.mode != blrb_pkg::MODE_PWM_I2C_LIN);
  assign o_use_i2c = en_sync_r && (cfg_view.mode != blrb_pkg::MODE_PWM_SW_LIN);
  assign o_log_mode = cfg_view.mode == blrb_pkg::MODE_SW_I2C_LOG;

  // dither flags codes 60+64N and 61+64N when not disabled
  assign o_dither_now = !cfg_view.dither_dis
                        && i2c_code_r[5:1] == blrb_pkg::DITHER_MATCH; // [RULE_10]

  // consumer keeps its own defaults until this register is written
  assign o_light_cfg_valid = light_wr_r; // [RULE_12]
  assign o_peak_code = light_r[blrb_pkg::LIGHT_PEAK_LSB +: 4];
  assign o_entry_code = light_r[blrb_pkg::LIGHT_ENTRY_LSB +: 4];

  property p_lo_pending;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BRIGHT_LO)) |=> $stable(o_i2c_code);
  endproperty
  a_lo_pending: assert property (p_lo_pending) else $error("low byte applied early"); // [RULE_06]

  property p_hi_apply;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BRIGHT_HI))
      |=> o_i2c_code == {$past(i_wr_data), $past(lo_r)};
  endproperty
  a_hi_apply: assert property (p_hi_apply) else $error("brightness not applied"); // [RULE_05]

  property p_cfg_write;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_DIM_CFG)) |=> o_dim_cfg == $past(i_wr_data);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [RULE_01]

  property p_sw_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
    cfg_clear |=> o_sw_code == 11'h000 && sw_cnt_r == 4'h0;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("receiver not cleared"); // [RULE_22]

  property p_overflow;
    @(posedge i_clock) disable iff (i_sys_rst)
    (rx_load && !cfg_clear && sw_cnt_r > max_bits) |=> $stable(o_sw_code);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overlong sequence used"); // [RULE_20]

  property p_status_sticky;
    @(posedge i_clock) disable iff (i_sys_rst)
    (sts_lat_r[3] || sts_view.overtemp) |=> sts_lat_r[3] [*3];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("fault latch lost"); // [RULE_24]

  property p_light_valid;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(o_light_cfg_valid) |-> $past(wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_LIGHT_LOAD));
  endproperty
  a_light_valid: assert property (p_light_valid) else $error("03h valid without write"); // [RULE_12]

  property p_disabled_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    !en_sync_r |=> $stable(o_dim_cfg) && $stable(o_i2c_code) && $stable(o_boost_cfg);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("write while disabled"); // [RULE_26]

  property p_boost_write;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_ok && blrb_hit(i_wr_addr, blrb_pkg::ADDR_BOOST))
      |=> o_boost_cfg.audio_band_suppression_en == $past(i_wr_data[4])
          && o_boost_cfg.freq_code == $past(i_wr_data[3:0]);
  endproperty
  a_boost_write: assert property (p_boost_write) else $error("boost write lost"); // [RULE_14]

endmodule

`default_nettype wire

// ### blrb_single_wire_brightness_input_host.sv
// host model driving the open-drain single brightness wire
`default_nettype none

module blrb_sw_host (
  output logic o_line_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // host keeps its own timebase, unrelated in phase to the block clock
  localparam int HOST_HALF_NS = 160;
  logic hclk;

  initial
  begin
    hclk = 1'b0;
    o_line_oe = 1'b0; // released, pull-up holds the line high
    #7;
    forever #HOST_HALF_NS hclk = ~hclk;
  end

  task automatic pulse(input int low_ns);
    int n;
    n = low_ns / (2 * HOST_HALF_NS);
    @(posedge hclk);
    o_line_oe <= 1'b1;
    repeat (n) @(posedge hclk);
    o_line_oe <= 1'b0;
    // about 5 us high before the next symbol
    repeat (16) @(posedge hclk);
  endtask

  task automatic send_bit(input logic b);
    pulse(b ? 30000 : 105000);
  endtask

  // first bit sent is the most significant one
  task automatic send_word(input logic [10:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--)
      send_bit(bits[i]);
    pulse(250000);
  endtask
endmodule

`default_nettype wire

// ### blrb_backlight_regs_test.sv
// self-checking bench of the backlight register bank and single-wire receiver
`default_nettype none

module blrb_backlight_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_enable = 1'b1;
  logic i_wr_en = 1'b0;
  logic [7:0] i_wr_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic [7:0] i_rd_addr = 8'h00;
  blrb_pkg::blrb_status_t i_status = 8'h0F;
  logic line_oe;
  wire logic i_line;
  logic [7:0] o_rd_data;
  blrb_pkg::blrb_dim_cfg_t o_dim_cfg;
  blrb_pkg::blrb_boost_cfg_t o_boost_cfg;
  logic [10:0] o_i2c_code;
  logic [10:0] o_sw_code;
  logic o_use_pwm, o_use_sw, o_use_i2c, o_log_mode, o_dither_now;
  logic o_light_cfg_valid, o_interfaces_on;
  logic [3:0] o_peak_code, o_entry_code;
  int error_cnt = 0;
  int comparisons = 0;

  // pull-up on the wire: high unless the host pulls it down
  assign i_line = ~line_oe;
  always #20 i_clock = ~i_clock;

  blrb_backlight_regs DUT (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_enable(i_enable), .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
    .i_line(i_line), .i_status(i_status), .o_rd_data(o_rd_data), .o_dim_cfg(o_dim_cfg),
    .o_boost_cfg(o_boost_cfg), .o_i2c_code(o_i2c_code), .o_sw_code(o_sw_code),
    .o_use_pwm(o_use_pwm), .o_use_sw(o_use_sw), .o_use_i2c(o_use_i2c),
    .o_log_mode(o_log_mode), .o_dither_now(o_dither_now),
    .o_light_cfg_valid(o_light_cfg_valid), .o_peak_code(o_peak_code),
    .o_entry_code(o_entry_code), .o_interfaces_on(o_interfaces_on)
  );

  blrb_sw_host host (
    .o_line_oe(line_oe)
  );

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_en <= 1'b1;
    i_wr_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
    #1;
  endtask

  // read data is registered on the same edge that samples the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_rd_addr <= a;
    @(posedge i_clock);
    #1;
    d = o_rd_data;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] adr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h05};
    logic [7:0] exp [7] = '{8'hFF, 8'h07, 8'hFF, 8'h00, 8'hFA, 8'h0F, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd(adr[i], d);
      chk("reset readback", {3'h0, exp[i]}, {3'h0, d});
    end
    chk("i2c code", 11'h7FF, o_i2c_code);
    chk("line code", 11'h000, o_sw_code);
  endtask

  task automatic t_bright();
    logic [7:0] d;
    wr(8'h01, 8'h05); // upper bits reserved, written as zero
    chk("low bits pending", 11'h7FF, o_i2c_code);
    rd(8'h01, d);
    chk("low reg read", 11'h005, {3'h0, d});
    wr(8'h00, 8'h80);
    chk("applied code", 11'h405, o_i2c_code);
    wr(8'h02, 8'hFB);
    wr(8'h01, 8'h04);
    wr(8'h00, 8'h07);
    chk("dither at 60", 11'h001, {10'h0, o_dither_now});
    wr(8'h00, 8'h08);
    chk("no dither at 68", 11'h000, {10'h0, o_dither_now});
  endtask

  task automatic t_cfg();
    logic [7:0] v;
    logic [5:0] pat [2] = '{6'h2A, 6'h15};
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
      begin
        v = {m[1:0], pat[p]};
        wr(8'h02, v);
        chk("config", {3'h0, v}, {3'h0, o_dim_cfg});
        chk("log", {10'h0, m == 1}, {10'h0, o_log_mode});
        chk("pwm", {10'h0, m[1]}, {10'h0, o_use_pwm});
        chk("line use", {10'h0, m != 2}, {10'h0, o_use_sw});
        chk("i2c", {10'h0, m != 3}, {10'h0, o_use_i2c});
      end
  endtask

  task automatic t_light();
    logic [7:0] d;
    chk("light valid before", 11'h000, {10'h0, o_light_cfg_valid});
    wr(8'h03, 8'hA5);
    chk("light valid", 11'h001, {10'h0, o_light_cfg_valid});
    chk("peak entry", 11'h0A5, {3'h0, o_peak_code, o_entry_code});
    wr(8'h04, 8'h2B);
    chk("boost", 11'h02B, {3'h0, o_boost_cfg});
    rd(8'h04, d);
    chk("boost read", 11'h02B, {3'h0, d});
  endtask

  task automatic t_status();
    logic [7:0] d;
    for (int k = 4; k < 8; k++)
    begin
      @(posedge i_clock);
      i_status <= 8'h0A | (8'h01 << k);
      @(posedge i_clock);
      i_status <= 8'h0A;
      repeat (3) @(posedge i_clock);
      rd(8'h10, d);
      // events accumulate: bits 4..k are latched by now
      chk("status latch", {3'h0, 8'h0A | (8'hF0 & (8'hFF >> (7 - k)))}, {3'h0, d});
    end
  endtask

  task automatic t_enable();
    @(posedge i_clock);
    i_enable <= 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    chk("interfaces off", 11'h000, {10'h0, o_interfaces_on});
    wr(8'h00, 8'h11);
    chk("code kept", 11'h044, o_i2c_code);
    @(posedge i_clock);
    i_enable <= 1'b1;
    repeat (4) @(posedge i_clock);
    #1;
    chk("interfaces on", 11'h001, {10'h0, o_interfaces_on});
  endtask

  task automatic t_line();
    wr(8'h02, 8'hFF);
    host.send_word(11'h096, 8);
    repeat (5) @(posedge i_clock);
    chk("line 8 bits", 11'h096, o_sw_code);
    host.send_word(11'h01B, 5);
    repeat (5) @(posedge i_clock);
    chk("line 5 bits scaled", 11'h0DE, o_sw_code);
    host.send_word(11'h1FF, 9);
    repeat (5) @(posedge i_clock);
    chk("line too long", 11'h0DE, o_sw_code);
    wr(8'h02, 8'h00);
    chk("line cleared", 11'h000, o_sw_code);
    wr(8'h02, 8'h40);
    host.send_word(11'h01B, 5);
    repeat (5) @(posedge i_clock);
    chk("line log scaled", 11'h6F7, o_sw_code);
  endtask

  initial
  begin
    repeat (90000) @(posedge i_clock);
    error_cnt++;
    $display("[FAIL] run time expected below limit seen limit");
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (5) @(posedge i_clock);
    t_reset();
    t_bright();
    t_cfg();
    t_light();
    t_status();
    // code is 044 here, so a dropped write of 11 stays visible
    t_enable();
    t_line();
    summarize();
  end
endmodule

`default_nettype wire
